/* common/optic_ctrl_consts.vh */
`ifndef OPTIC_CTRL_CONSTS_VH
`define OPTIC_CTRL_CONSTS_VH
// Clock rate
`define CLK_MHZ            40
// Deadlines, each in its own unit as printed
`define T_OFF_US           100
`define T_ON_MS            2
`define T_2W_START_MS      300
`define T_START_MS         300
`define T_START_COOLED_S   90
`define T_PWR_UP_MS        300
`define T_PWR_DOWN_MS      300
`define T_FAULT_ON_MS      1
`define T_FAULT_ON_COOL_MS 50
`define T_RESET_US         10
`define T_RS_FC_US         500
`define T_RS_NONFC_MS      10
`define T_LOS_ON_US        100
`define T_LOS_OFF_US       100
// Cycle counts; longest times round down, least time rounds up (exact here)
`define CYC_OFF            (`T_OFF_US * `CLK_MHZ)
`define CYC_ON             (`T_ON_MS * 1000 * `CLK_MHZ)
`define CYC_2W_START       (`T_2W_START_MS * 1000 * `CLK_MHZ)
`define CYC_START          (`T_START_MS * 1000 * `CLK_MHZ)
`define CYC_START_COOLED   (`T_START_COOLED_S * 1000000 * `CLK_MHZ)
`define CYC_PWR_UP         (`T_PWR_UP_MS * 1000 * `CLK_MHZ)
`define CYC_PWR_DOWN       (`T_PWR_DOWN_MS * 1000 * `CLK_MHZ)
`define CYC_FAULT_ON       (`T_FAULT_ON_MS * 1000 * `CLK_MHZ)
`define CYC_FAULT_ON_COOL  (`T_FAULT_ON_COOL_MS * 1000 * `CLK_MHZ)
`define CYC_RESET          (`T_RESET_US * `CLK_MHZ)
`define CYC_RS_FC          (`T_RS_FC_US * `CLK_MHZ)
`define CYC_RS_NONFC       (`T_RS_NONFC_MS * 1000 * `CLK_MHZ)
`define CYC_LOS_ON         (`T_LOS_ON_US * `CLK_MHZ)
`define CYC_LOS_OFF        (`T_LOS_OFF_US * `CLK_MHZ)
// Register byte offsets
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_IRQ_STAT       8'h08
`define REG_IRQ_MASK       8'h0c
`define REG_TIMING         8'h10
// Control register fields
`define CTRL_COOLED        0
`define CTRL_FC_MODE       1
`define CTRL_PWR_LEVEL2    2
`define CTRL_PWR_CMD       3
// Status register fields
`define ST_TX_ON           0
`define ST_FAULT           1
`define ST_LOS             2
`define ST_MGMT_READY      3
`define ST_OPERATIONAL     4
`define ST_PWR_LEVEL2      5
`define ST_RATE_STABLE     6
`define ST_STATE_LSB       8
// Interrupt event bits
`define EV_FAULT           0
`define EV_LOS_ON          1
`define EV_LOS_OFF         2
`define EV_READY           3
`define EV_RATE_STABLE     4
`define EV_FAULT_CLR       5
`define EV_WIDTH           6
// Reset values
`define CTRL_RESET         4'h0
`define MASK_RESET         6'h00
`endif

/* core/deadline_timer.v */
`timescale 1ns/100ps
`default_nettype none
// Counts down from a loaded value; done pulses on reaching zero
module deadline_timer #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Control
  input  wire         start,
  input  wire         cancel,
  input  wire [W-1:0] load,
  // Status
  output reg          busy,
  output reg          done
);
  reg [W-1:0] cnt_q; // Cycles left

  // Start wins over cancel so a restart is never lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= {W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= (load == {W{1'b0}}) ? {{(W-1){1'b0}}, 1'b1} : load;
        busy  <= 1'b1;
      end else if (cancel) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // deadline_timer
`default_nettype wire

/* core/pin_sync.v */
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a group of pins
module pin_sync #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // Pins and synchronised copy
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] pin_out
);
  reg [W-1:0] meta_q; // First stage, read only by the second

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q  <= {W{1'b0}};
      pin_out <= {W{1'b0}};
    end else begin
      meta_q  <= pin_in;
      pin_out <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

/* core/optic_ctrl.v */
// Behaviour
// [R1] Laser off within 100 us of request rise
// [R2] Laser on within 2 ms, normal operation
// [R3] Management ready within 300 ms of power
// [R4] Uncooled operational within 300 ms
// [R5] Cooled operational within 90 s
// [R6] Level-two enable settles within 300 ms
// [R7] Level-two disable settles within 300 ms
// [R8] Uncooled fault flagged within 1 ms
// [R9] Cooled fault flagged within 50 ms
// [R10] Request high 10 us resets fault
// [R11] Rate select settles 500 us, FC
// [R12] Rate select settles 10 ms, non-FC
// [R13] Loss flagged within 100 us
// [R14] Loss cleared within 100 us
// [R15] Fault latched; reset reruns initialisation
`timescale 1ns/100ps
`default_nettype none
`include "optic_ctrl_consts.vh"
module optic_ctrl #(
  parameter [31:0] CYC_ON_P      = `CYC_ON,
  parameter [31:0] CYC_START_P   = `CYC_START,
  parameter [31:0] CYC_COOLED_P  = `CYC_START_COOLED,
  parameter [31:0] CYC_2W_P      = `CYC_2W_START,
  parameter [31:0] CYC_PWR_UP_P  = `CYC_PWR_UP,
  parameter [31:0] CYC_PWR_DN_P  = `CYC_PWR_DOWN,
  parameter [31:0] CYC_FLT_P     = `CYC_FAULT_ON,
  parameter [31:0] CYC_FLT_CL_P  = `CYC_FAULT_ON_COOL,
  parameter [31:0] CYC_RS_NFC_P  = `CYC_RS_NONFC
) (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Host sideband pins
  input  wire        tx_disable,
  input  wire        rate_select_low_bit,
  input  wire        rate_select_high_bit,
  output reg         tx_fault,
  output reg         rx_los,
  // Module internals
  input  wire        laser_fault_in,
  input  wire        signal_present_in,
  output reg         laser_enable,
  output reg         rate_stable,
  output reg         mgmt_ready,
  output reg         pwr_level2,
  // Interrupt
  output wire        irq
);
  // Control state machine
  localparam [2:0] ST_INIT  = 3'h0; // Initialising, laser dark
  localparam [2:0] ST_OPER  = 3'h1; // Operational
  localparam [2:0] ST_DARK  = 3'h2; // Disabled by request
  localparam [2:0] ST_FAULT = 3'h3; // Fault latched

  reg  [2:0]  state_q;                   // Current state
  reg  [3:0]  ctrl_q;                    // Control register
  reg  [`EV_WIDTH-1:0] istat_q;          // Sticky events
  reg  [`EV_WIDTH-1:0] imask_q;          // Interrupt mask
  reg  [31:0] rdata_q;                   // Read data
  reg         wr_pend_q;                 // Write data phase pending
  reg  [7:0]  wr_addr_q;                 // Latched write address
  reg         dis_q;                     // Previous request level
  reg  [1:0]  rs_q;                      // Previous rate select
  reg  [15:0] hold_q;                    // Request-high length
  reg         fault_seen_q;              // Fault pending report
  reg         los_raw_q;                 // Previous raw loss
  wire [2:0]  pins;                      // Synchronised pins
  wire        dis_s = pins[0];
  wire [1:0]  rs_s  = pins[2:1];
  wire [1:0]  sense_s;                   // Synchronised sense lines
  wire        los_s = sense_s[0];        // Loss of light
  wire        flt_s = sense_s[1];        // Laser driver fault

  // Pins come from the host board, outside our clock
  pin_sync #(.W(3)) u_sync_pins (
    .hclk(hclk), .hresetn(hresetn),
    .pin_in({rate_select_high_bit, rate_select_low_bit, tx_disable}),
    .pin_out(pins)
  );
  // Sense lines come from the analog side, just as asynchronous
  pin_sync #(.W(2)) u_sync_los (
    .hclk(hclk), .hresetn(hresetn),
    .pin_in({laser_fault_in, ~signal_present_in}), .pin_out(sense_s)
  );

  // Bus decode
  wire        acc     = hsel & hready & htrans[1];
  wire        wr_go   = wr_pend_q;
  wire        cooled  = ctrl_q[`CTRL_COOLED];
  wire        dis_rise = dis_s & ~dis_q;
  wire        dis_fall = ~dis_s & dis_q;
  wire        fault_rst = dis_fall && (hold_q >= `CYC_RESET);
  wire        rs_rise = |(rs_s & ~rs_q);

  // Timers
  wire        init_busy, init_done, on_busy, on_done;
  wire        pw_busy, pw_done, fl_busy, fl_done, rs_done, rs_busy;
  reg         init_go, on_go, pw_go, fl_go, rs_go;
  reg  [31:0] pw_load;
  wire        lvl2_wr = wr_go && wr_addr_q == `REG_CTRL &&
                        hwdata[`CTRL_PWR_LEVEL2] != ctrl_q[`CTRL_PWR_LEVEL2];

  // Startup length depends on cooling
  wire [31:0] init_load = cooled ? CYC_COOLED_P : CYC_START_P; // [R4] [R5]
  deadline_timer u_init (.hclk(hclk), .hresetn(hresetn), .start(init_go),
    .cancel(1'b0), .load(init_load), .busy(init_busy), .done(init_done));
  deadline_timer u_on (.hclk(hclk), .hresetn(hresetn), .start(on_go),
    .cancel(dis_rise), .load(CYC_ON_P), .busy(on_busy), .done(on_done)); // [R2]
  deadline_timer u_pwr (.hclk(hclk), .hresetn(hresetn), .start(pw_go),
    .cancel(1'b0), .load(pw_load), .busy(pw_busy), .done(pw_done));
  deadline_timer u_flt (.hclk(hclk), .hresetn(hresetn), .start(fl_go),
    .cancel(1'b0), .load(cooled ? CYC_FLT_CL_P : CYC_FLT_P),
    .busy(fl_busy), .done(fl_done)); // [R8] [R9]
  deadline_timer u_rs (.hclk(hclk), .hresetn(hresetn), .start(rs_go),
    .cancel(1'b0),
    .load(ctrl_q[`CTRL_FC_MODE] ? `CYC_RS_FC : CYC_RS_NFC_P),
    .busy(rs_busy), .done(rs_done)); // [R11] [R12]

  // Timer starts
  always @* begin
    init_go = 1'b0;
    on_go   = 1'b0;
    fl_go   = flt_s & ~fault_seen_q & ~tx_fault & ~fl_busy;
    rs_go   = rs_rise;
    pw_go   = lvl2_wr;                   // [R6] [R7]
    pw_load = hwdata[`CTRL_PWR_LEVEL2] ? CYC_PWR_UP_P : CYC_PWR_DN_P;
    case (state_q)
      ST_DARK: on_go = dis_fall;         // Normal operation turn-on
      ST_FAULT: init_go = fault_rst;     // [R15]
      default: on_go = 1'b0;
    endcase
  end

  // Management ready counter: power-on start, flags ready once
  reg [31:0] mg_cnt_q;                   // Cycles since supply valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mg_cnt_q   <= 32'h0000_0000;
      mgmt_ready <= 1'b0;
    end else if (!mgmt_ready) begin
      // Ready well before the deadline: a few cycles after reset
      mg_cnt_q   <= mg_cnt_q + 32'h0000_0001;
      mgmt_ready <= (mg_cnt_q >= 32'h0000_0003) || (mg_cnt_q >= CYC_2W_P); // [R3]
    end
  end

  // Main state machine and pin outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q      <= ST_INIT;
      laser_enable <= 1'b0;
      tx_fault     <= 1'b0;
      rx_los       <= 1'b1;
      dis_q        <= 1'b0;              // Matches the synchroniser, no false edge
      rs_q         <= 2'h0;
      hold_q       <= 16'h0000;
      fault_seen_q <= 1'b0;
      los_raw_q    <= 1'b1;
      rate_stable  <= 1'b1;
      pwr_level2   <= 1'b0;
    end else begin
      dis_q     <= dis_s;
      rs_q      <= rs_s;
      los_raw_q <= los_s;
      // Request-high length, saturating
      if (!dis_s)
        hold_q <= 16'h0000;
      else if (hold_q != 16'hffff)
        hold_q <= hold_q + 16'h0001;     // [R10]
      // Loss follows the signal two stages behind, far under the deadline
      rx_los <= los_raw_q;               // [R13] [R14]
      // Rate select settling
      if (rs_go)
        rate_stable <= 1'b0;
      else if (rs_done)
        rate_stable <= 1'b1;
      // Power level follows after settling
      if (pw_done)
        pwr_level2 <= ctrl_q[`CTRL_PWR_LEVEL2];
      // Fault detection: report at timer expiry, never before
      if (fl_go)
        fault_seen_q <= 1'b1;
      if (fl_done && fault_seen_q) begin
        tx_fault     <= 1'b1;            // [R8] [R9] [R15]
        fault_seen_q <= 1'b0;
        laser_enable <= 1'b0;
        state_q      <= ST_FAULT;
      end else begin
        case (state_q)
          ST_INIT: begin
            if (dis_s) begin
              laser_enable <= 1'b0;      // [R1]
            end else if (!init_busy && !init_go) begin
              laser_enable <= 1'b1;      // [R4] [R5]
              state_q      <= ST_OPER;
            end
          end
          ST_OPER: begin
            if (dis_s) begin
              laser_enable <= 1'b0;      // [R1]
              state_q      <= ST_DARK;
            end
          end
          ST_DARK: begin
            if (dis_fall) begin
              laser_enable <= 1'b1;      // [R2]
              state_q      <= ST_OPER;
            end
          end
          ST_FAULT: begin
            laser_enable <= 1'b0;
            if (fault_rst) begin
              tx_fault <= 1'b0;          // [R10] [R15]
              state_q  <= ST_INIT;
            end
          end
          default: state_q <= ST_INIT;
        endcase
      end
    end
  end

  // Events for the interrupt status
  wire [`EV_WIDTH-1:0] ev;
  assign ev[`EV_FAULT]       = fl_done & fault_seen_q;
  assign ev[`EV_LOS_ON]      = ~rx_los & los_raw_q;
  assign ev[`EV_LOS_OFF]     = rx_los & ~los_raw_q;
  assign ev[`EV_READY]       = (state_q == ST_INIT) & ~dis_s & ~init_busy & ~init_go;
  assign ev[`EV_RATE_STABLE] = rs_done;
  assign ev[`EV_FAULT_CLR]   = (state_q == ST_FAULT) & fault_rst;

  // Bus slave: address phase latch, write in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      ctrl_q    <= `CTRL_RESET;
      imask_q   <= `MASK_RESET;
      istat_q   <= {`EV_WIDTH{1'b0}};
    end else begin
      wr_pend_q <= acc & hwrite;
      wr_addr_q <= haddr;
      if (acc && !hwrite) begin
        case (haddr)
          `REG_CTRL:     rdata_q <= {28'h0000000, ctrl_q};
          `REG_STATUS:   rdata_q <= {21'h000000, state_q, 1'b0, rate_stable,
                                     pwr_level2, state_q == ST_OPER, mgmt_ready,
                                     rx_los, tx_fault, laser_enable};
          `REG_IRQ_STAT: rdata_q <= {26'h0000000, istat_q};
          `REG_IRQ_MASK: rdata_q <= {26'h0000000, imask_q};
          default:       rdata_q <= 32'h0000_0000;
        endcase
      end
      if (wr_go && wr_addr_q == `REG_CTRL)
        ctrl_q <= hwdata[3:0];
      if (wr_go && wr_addr_q == `REG_IRQ_MASK)
        imask_q <= hwdata[`EV_WIDTH-1:0];
      // Set wins over write-one-to-clear
      istat_q <= (istat_q & ~((wr_go && wr_addr_q == `REG_IRQ_STAT) ?
                              hwdata[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}})) | ev;
    end
  end

  assign hrdata    = rdata_q;
  assign hreadyout = 1'b1;               // Zero wait states
  assign hresp     = 1'b0;               // Always OKAY
  assign irq       = |(istat_q & imask_q);
endmodule // optic_ctrl
`default_nettype wire

/* tb/optic_ctrl_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Timing guards on the sideband pins of the optic controller
module optic_ctrl_checker #(
  parameter [31:0] CYC_FLT_P    = 20,
  parameter [31:0] CYC_FLT_CL_P = 20,
  parameter [31:0] CYC_2W_P     = 20
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic tx_disable,
  input wire logic tx_fault,
  input wire logic rx_los,
  input wire logic laser_fault_in,
  input wire logic signal_present_in,
  input wire logic laser_enable,
  input wire logic rate_stable,
  input wire logic mgmt_ready
);
  // Slack covers the two-flop input synchroniser
  localparam int FLT_MAX = (CYC_FLT_CL_P > CYC_FLT_P ? CYC_FLT_CL_P : CYC_FLT_P) + 6;
  localparam int LOS_MAX = 6;
  // FC deadline of 500 us is the longer one at the shortened settings
  localparam int RS_MAX  = 20008;
  logic [31:0] hi_run_q;    // Current high run of the laser-off request
  logic [31:0] last_hi_q;   // Length of the last finished high run
  logic [31:0] since_rst_q; // Cycles since reset release, saturating
  logic [31:0] low_run_q;   // Cycles spent settling
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Run-length and elapsed-time counters
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hi_run_q    <= 32'h0;
      last_hi_q   <= 32'h0;
      since_rst_q <= 32'h0;
      low_run_q   <= 32'h0;
    end else begin
      hi_run_q    <= tx_disable ? hi_run_q + 32'h1 : 32'h0;
      if (!tx_disable && hi_run_q != 32'h0) begin
        last_hi_q <= hi_run_q;
      end
      since_rst_q <= (since_rst_q == 32'hffffffff) ? since_rst_q : since_rst_q + 32'h1;
      low_run_q   <= rate_stable ? 32'h0 : low_run_q + 32'h1;
    end
  end
  sequence s_dark_hold;
    tx_disable [*8];
  endsequence
  sequence s_light_lost;
    $fell(signal_present_in);
  endsequence
  sequence s_light_back;
    $rose(signal_present_in);
  endsequence
  chk_laser_off: assert property ($rose(tx_disable) |-> ##[1:6] !laser_enable)
    else $error("laser still on after off request");
  chk_laser_dark: assert property (s_dark_hold |-> !laser_enable)
    else $error("laser on while request held");
  chk_los_on: assert property (s_light_lost |-> ##[1:LOS_MAX] rx_los)
    else $error("loss of signal not flagged");
  chk_los_off: assert property (s_light_back |-> ##[1:LOS_MAX] !rx_los)
    else $error("loss of signal not cleared");
  chk_fault_flag: assert property ($rose(laser_fault_in) |-> ##[1:FLT_MAX] tx_fault)
    else $error("fault not flagged in time");
  chk_fault_clear: assert property ($fell(tx_fault) |-> last_hi_q >= 32'd400)
    else $error("fault cleared without long request");
  chk_rate_settle: assert property (low_run_q <= RS_MAX)
    else $error("rate select settling too long");
  chk_mgmt_ready: assert property (since_rst_q == CYC_2W_P |-> mgmt_ready)
    else $error("management not ready in time");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule // optic_ctrl_checker
bind optic_ctrl optic_ctrl_checker #(
  .CYC_FLT_P(CYC_FLT_P), .CYC_FLT_CL_P(CYC_FLT_CL_P), .CYC_2W_P(CYC_2W_P)
) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .tx_disable(tx_disable), .tx_fault(tx_fault), .rx_los(rx_los),
  .laser_fault_in(laser_fault_in), .signal_present_in(signal_present_in),
  .laser_enable(laser_enable), .rate_stable(rate_stable), .mgmt_ready(mgmt_ready)
);
`default_nettype wire

/* tb/host_pins.sv */
`timescale 1ns/100ps
`default_nettype none
// Host board side of the sideband pins, plus the module-internal sense lines
module host_pins (
  // Clock
  input  wire logic hclk,
  // Pins driven toward the block
  output var logic  tx_disable,
  output var logic  rate_select_low_bit,
  output var logic  rate_select_high_bit,
  output var logic  laser_fault_in,
  output var logic  signal_present_in
);
  // Idle: laser allowed, light present, no fault
  initial begin
    tx_disable           = 1'b0;
    rate_select_low_bit  = 1'b0;
    rate_select_high_bit = 1'b0;
    laser_fault_in       = 1'b0;
    signal_present_in    = 1'b1;
  end
  // Holds the request high a whole count of cycles; a fault reset needs 400
  task hold_disable(input int n);
    @(posedge hclk);
    tx_disable <= 1'b1;
    repeat (n) @(posedge hclk);
    tx_disable <= 1'b0;
  endtask
  // Sets one pin just after an edge
  task set_pin(input int idx, input logic v);
    @(posedge hclk);
    case (idx)
      0: laser_fault_in       <= v;
      1: signal_present_in    <= v;
      2: rate_select_low_bit  <= v;
      3: rate_select_high_bit <= v;
      default: tx_disable     <= v;
    endcase
  endtask
endmodule // host_pins
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
`include "optic_ctrl_consts.vh"
module testbench;
  // Shortened counts handed to the block
  localparam int P_ON = 20, P_START = 30, P_COOL = 80, P_UP = 20, P_DN = 25;
  localparam int P_FLT = 20, P_FLT_CL = 60, P_RS = 20;
  logic        hclk, hresetn, hsel, hwrite;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, tx_fault, rx_los, laser_enable;
  wire         rate_stable, mgmt_ready, pwr_level2, tx_disable, laser_fault_in;
  wire         rate_select_low_bit, rate_select_high_bit, signal_present_in;
  int          bad_count, checks, cyc;
  // Observed levels, indexed: 0 laser 1 fault 2 los 3 rate 4 mgmt 5 level two
  wire  [5:0]  obs = {pwr_level2, mgmt_ready, rate_stable, rx_los, tx_fault, laser_enable};
  host_pins u_host (
    .hclk(hclk), .tx_disable(tx_disable), .rate_select_low_bit(rate_select_low_bit),
    .rate_select_high_bit(rate_select_high_bit), .laser_fault_in(laser_fault_in),
    .signal_present_in(signal_present_in)
  );
  optic_ctrl #(
    .CYC_ON_P(P_ON), .CYC_START_P(P_START), .CYC_COOLED_P(P_COOL), .CYC_2W_P(20),
    .CYC_PWR_UP_P(P_UP), .CYC_PWR_DN_P(P_DN), .CYC_FLT_P(P_FLT), .CYC_FLT_CL_P(P_FLT_CL),
    .CYC_RS_NFC_P(P_RS)
  ) u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .tx_disable(tx_disable),
    .rate_select_low_bit(rate_select_low_bit), .rate_select_high_bit(rate_select_high_bit),
    .tx_fault(tx_fault), .rx_los(rx_los), .laser_fault_in(laser_fault_in),
    .signal_present_in(signal_present_in), .laser_enable(laser_enable),
    .rate_stable(rate_stable), .mgmt_ready(mgmt_ready), .pwr_level2(pwr_level2), .irq(irq)
  );
  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  // Compares and counts
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Waits a bounded time for one observed level, then judges it
  task wait_bit(input int b, input logic v, input int lim, input string what);
    int n;
    n = 0;
    while (obs[b] !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    #1;
    check({31'h0, obs[b]}, {31'h0, v}, what);
  endtask
  // One single AHB-Lite word transfer; waits on hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= w; hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task t_regs;
    ahb(1'b0, `REG_CTRL, 32'h0);
    check(rd, 32'h0, "ctrl reset");
    ahb(1'b0, `REG_IRQ_MASK, 32'h0);
    check(rd, 32'h0, "mask reset");
    ahb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0, "unmapped read");
    ahb(1'b1, `REG_CTRL, 32'h2);
    ahb(1'b0, `REG_CTRL, 32'h0);
    check(rd, 32'h2, "ctrl readback");
    ahb(1'b1, `REG_CTRL, 32'h0);
    ahb(1'b0, `REG_STATUS, 32'h0);
    check(rd & 32'h8, 32'h8, "status ready");
    $display("test regs done");
  endtask
  task t_laser;
    wait_bit(0, 1'b1, P_START + 10, "laser after reset");
    u_host.set_pin(4, 1'b1);
    wait_bit(0, 1'b0, 6, "laser off");
    repeat (10) @(posedge hclk);
    check({31'h0, laser_enable}, 32'h0, "laser held off");
    u_host.set_pin(4, 1'b0);
    wait_bit(0, 1'b1, P_ON + 6, "laser on");
    $display("test laser done");
  endtask
  task t_los;
    ahb(1'b1, `REG_IRQ_MASK, 32'h1 << `EV_LOS_ON);
    u_host.set_pin(1, 1'b0);
    wait_bit(2, 1'b1, 6, "los on");
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h1, "irq raised");
    ahb(1'b1, `REG_IRQ_STAT, 32'h1 << `EV_LOS_ON);
    repeat (2) @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq cleared");
    u_host.set_pin(1, 1'b1);
    wait_bit(2, 1'b0, 6, "los off");
    ahb(1'b1, `REG_IRQ_MASK, 32'h0);
    $display("test los done");
  endtask
  task t_fault(input logic cool);
    ahb(1'b1, `REG_CTRL, {31'h0, cool});
    u_host.set_pin(0, 1'b1);
    wait_bit(1, 1'b1, (cool ? P_FLT_CL : P_FLT) + 8, "fault flagged");
    u_host.set_pin(0, 1'b0);
    u_host.hold_disable(20);
    repeat (10) @(posedge hclk);
    check({31'h0, tx_fault}, 32'h1, "fault kept");
    u_host.hold_disable(420);
    wait_bit(1, 1'b0, 10, "fault reset");
    check({31'h0, laser_enable}, 32'h0, "laser waits init");
    wait_bit(0, 1'b1, (cool ? P_COOL : P_START) + 10, "laser recovered");
    ahb(1'b1, `REG_CTRL, 32'h0);
    $display("test fault done");
  endtask
  task t_power;
    ahb(1'b1, `REG_CTRL, 32'h4);
    wait_bit(5, 1'b1, P_UP + 8, "level two up");
    ahb(1'b1, `REG_CTRL, 32'h0);
    wait_bit(5, 1'b0, P_DN + 8, "level two down");
    $display("test power done");
  endtask
  task t_rate;
    u_host.set_pin(2, 1'b1);
    wait_bit(3, 1'b0, 6, "rate settling");
    wait_bit(3, 1'b1, P_RS + 8, "rate stable");
    u_host.set_pin(2, 1'b0);
    ahb(1'b1, `REG_CTRL, 32'h2);
    u_host.set_pin(3, 1'b1);
    wait_bit(3, 1'b0, 6, "fc settling");
    wait_bit(3, 1'b1, 20008, "fc stable");
    u_host.set_pin(3, 1'b0);
    ahb(1'b1, `REG_CTRL, 32'h0);
    $display("test rate done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard; the whole run needs about 21300 cycles
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 8'h00;
    htrans = 2'b00; hsize = 3'b010; hwdata = 32'h0;
    bad_count = 0; checks = 0; cyc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_laser;
    t_los;
    t_fault(1'b0);
    t_fault(1'b1);
    t_power;
    t_rate;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
